// >>> core/pz_cfg.svh
`ifndef PZ_CFG_SVH
`define PZ_CFG_SVH

// Special-function-register addresses
`define PZ_ADDR_LATCH 8'h80
`define PZ_ADDR_OD_SEL 8'hd4
`define PZ_ADDR_PWM_CTRL 8'hdc
`define PZ_ADDR_CHSEL_HIGH 8'he1
`define PZ_ADDR_CHSEL_LOW 8'he2
`define PZ_ADDR_ALT_SEL 8'he3
`define PZ_ADDR_PULL_DIS 8'he4
`define PZ_ADDR_DIR 8'hf4

// Reset values
`define PZ_LATCH_RST 8'hff
`define PZ_OD_SEL_RST 8'h00
`define PZ_PWM_CTRL_RST 8'h00
`define PZ_CHSEL_HIGH_RST 8'hff
`define PZ_CHSEL_LOW_RST 8'hff
`define PZ_ALT_SEL_RST 8'h00
`define PZ_PULL_DIS_RST 8'h00
`define PZ_DIR_RST 8'hff

// Field positions
`define PZ_ALT_TX_BIT 2
`define PZ_ALT_TMR_BIT 3
`define PZ_ALT_PWM0_BIT 4
`define PZ_PWM6_BIT 0
`define PZ_CHLOW_MSB 7
`define PZ_CHLOW_LSB 4
`define PZ_CHHIGH_MSB 2
`define PZ_CHHIGH_LSB 0
`define PZ_ALT_RSVD_MASK 8'hfc

`endif

// >>> core/pz_cfg_if.sv
interface pz_cfg_if;
    import pz_pkg::*;
    pz_byte_t dir;
    pz_byte_t pullDis;
    pz_byte_t odSel;
    pz_byte_t latch;
    pz_byte_t analog;
    pz_pin0_src_t pin0Src;
    logic pwmPin6;
    logic txEnable;
    modport ctl (
        output dir, pullDis, odSel, latch, analog, pin0Src, pwmPin6, txEnable
    );
    modport pin (
        input dir, pullDis, odSel, latch, analog, pin0Src, pwmPin6, txEnable
    );
endinterface

// >>> core/pz_irq_detect.sv
module pz_irq_detect (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input pz_pkg::pz_irq_t pinLevel,
    input pz_pkg::pz_irq_t irqEnable,
    input wire logic [1:0] irqLevelMode,
    output pz_pkg::pz_irq_t irqReq
);
    import pz_pkg::*;

    pz_irq_t prev;
    pz_irq_t next_req;

    // Previous levels start high so an idle-high pin raises no false edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev <= 4'hf;
        end else if (ce) begin
            prev <= pinLevel;
        end
    end

    always_comb begin
        next_req[3] = irqEnable[3] & prev[3] & ~pinLevel[3];
        next_req[2] = irqEnable[2] & ~prev[2] & pinLevel[2];
        for (int i = 0; i < 2; i++) begin
            next_req[i] = irqEnable[i] & ~pinLevel[i]
                & (irqLevelMode[i] | prev[i]);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqReq <= 4'h0;
        end else if (ce) begin
            irqReq <= next_req;
        end
    end

    rise_two_a: assert property (@(posedge mclk) disable iff (rst)
        ce && !pinLevel[2] ##1 ce && irqEnable[2] && pinLevel[2] |=> irqReq[2])
        else $error("Rising edge on interrupt two missed");

    fall_three_a: assert property (@(posedge mclk) disable iff (rst)
        ce && pinLevel[3] ##1 ce && irqEnable[3] && !pinLevel[3] |=> irqReq[3])
        else $error("Falling edge on interrupt three missed");

    level_zero_a: assert property (@(posedge mclk) disable iff (rst)
        ce && irqEnable[0] && irqLevelMode[0] && !pinLevel[0] |=> irqReq[0])
        else $error("Low level on interrupt zero missed");

    edge_one_a: assert property (@(posedge mclk) disable iff (rst)
        ce && pinLevel[1] ##1 ce && irqEnable[1] && !pinLevel[1] |=> irqReq[1])
        else $error("Falling edge on interrupt one missed");
endmodule // pz_irq_detect

// >>> core/pz_pin_drive.sv
`include "pz_cfg.svh"
module pz_pin_drive (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    pz_cfg_if.pin cfg,
    input wire logic timerOverflow,
    input wire logic pwmWave,
    input wire logic serialMode0,
    input wire logic txData,
    input wire logic shiftClk,
    input wire logic rxdOut,
    input wire logic rxdOe,
    output pz_pkg::pz_byte_t pinOut,
    output pz_pkg::pz_byte_t pinOe,
    output pz_pkg::pz_byte_t pullupEn,
    output pz_pkg::pz_byte_t analogEn
);
    import pz_pkg::*;

    pz_byte_t next_out;
    pz_byte_t next_oe;
    pz_byte_t next_pull;
    pz_byte_t altForce;

    always_comb begin
        next_out = cfg.latch;
        altForce = 8'h00;
        case (cfg.pin0Src)
            PZ_SRC_PWM: begin
                next_out[0] = pwmWave;
                altForce[0] = 1'b1;
            end
            PZ_SRC_TIMER: begin
                next_out[0] = timerOverflow;
                altForce[0] = 1'b1;
            end
            default: ;
        endcase
        if (cfg.pwmPin6) begin
            next_out[6] = pwmWave;
            altForce[6] = 1'b1;
        end
        if (cfg.txEnable) begin
            next_out[2] = serialMode0 ? shiftClk : txData;
            altForce[2] = 1'b1;
        end
        for (int i = 0; i < 8; i++) begin
            // Open drain only sinks; the high level comes from the pull-up
            next_oe[i] = (altForce[i] | ~cfg.dir[i]) & (~cfg.odSel[i] | ~next_out[i]);
        end
        if (cfg.txEnable && serialMode0) begin
            next_out[1] = rxdOut;
            next_oe[1] = rxdOe & (~cfg.odSel[1] | ~rxdOut);
        end
        next_oe = next_oe & ~cfg.analog;
        next_pull = ~cfg.pullDis & ~cfg.analog;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinOut <= 8'hff;
            pinOe <= 8'h00;
            pullupEn <= 8'hff;
            analogEn <= 8'h00;
        end else if (ce) begin
            pinOut <= next_out;
            pinOe <= next_oe;
            pullupEn <= next_pull;
            analogEn <= cfg.analog;
        end
    end

    analog_no_drive_a: assert property (@(posedge mclk) disable iff (rst)
        (pinOe & analogEn) == 8'h00)
        else $error("Analog pin is being driven");

    pwm_priority_a: assert property (@(posedge mclk) disable iff (rst)
        ce && cfg.pin0Src == PZ_SRC_PWM |=> pinOut[0] == $past(pwmWave))
        else $error("Pin zero does not carry the pwm wave");

    od_high_float_a: assert property (@(posedge mclk) disable iff (rst)
        ce && cfg.odSel[7] && cfg.latch[7] |=> !pinOe[7])
        else $error("Open-drain pin drives high");

    pull_follow_a: assert property (@(posedge mclk) disable iff (rst)
        ce && !cfg.analog[0] |=> pullupEn[0] == !$past(cfg.pullDis[0]))
        else $error("Pull-up enable does not follow its control bit");
endmodule // pz_pin_drive

// >>> core/pz_pkg.sv
package pz_pkg;
    typedef logic [7:0] pz_byte_t;
    typedef logic [3:0] pz_irq_t;
    typedef enum logic [1:0] {
        PZ_SRC_LATCH,
        PZ_SRC_TIMER,
        PZ_SRC_PWM
    } pz_pin0_src_t;
endpackage

// >>> core/pz_port0.sv
// Contract
// - Direction bit 0 makes pin output, 1 input; resets to all inputs.
// - Pull-up control bit 0 enables pull-up, 1 disables; all enabled after reset.
// - Output-type bit 0 push-pull, 1 open-drain; resets to push-pull.
// - Data latch resets to all ones; drives outputs and is read back.
// - Enabled analog channel takes its pin regardless of digital settings.
// - Disabling the channel restores the earlier digital configuration.
// - Channel select bits are active low; reset value 1 disables.
// - Pins one to seven serve as analog channels zero to six.
// - Read-modify-write reads of the port return the latch, not pins.
// - Interrupt three input on pin three requests on falling edge.
// - Interrupt two input on pin two requests on rising edge.
// - Interrupt one input on pin one requests on falling edge or low level.
// - Interrupt zero input on pin zero requests on falling edge or low level.
// - Alternate select bit three drives timer overflow onto pin zero.
// - Alternate select bit four drives the pwm wave onto pin zero.
// - Pwm control bit zero drives the pwm wave onto pin six.
// - Pin two sends transmit data in mode 1, shift clock in mode 0.
// - Pin one receives data in mode 1, bidirectional data in mode 0.
// - Transmit enable routes transmit data to pin two ignoring its direction.
// - Upper four low channel-select bits enable channels zero to three.
`include "pz_cfg.svh"
module pz_port0 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input pz_pkg::pz_byte_t sfrAddr,
    input wire logic sfrWrite,
    input pz_pkg::pz_byte_t sfrWdata,
    input wire logic sfrRead,
    input wire logic sfrRmw,
    output pz_pkg::pz_byte_t sfrRdata,
    output logic sfrHit,
    input pz_pkg::pz_byte_t pinIn,
    output pz_pkg::pz_byte_t pinOut,
    output pz_pkg::pz_byte_t pinOe,
    output pz_pkg::pz_byte_t pullupEn,
    output pz_pkg::pz_byte_t analogEn,
    input wire logic timerOverflow,
    input wire logic pwmWave,
    input wire logic serialMode0,
    input wire logic txData,
    input wire logic shiftClk,
    input wire logic rxdOut,
    input wire logic rxdOe,
    output logic rxData,
    input pz_pkg::pz_irq_t irqEnable,
    input wire logic [1:0] irqLevelMode,
    output pz_pkg::pz_irq_t irqReq
);
    import pz_pkg::*;

    pz_byte_t latch;
    pz_byte_t odSel;
    pz_byte_t pwmCtrl;
    pz_byte_t chSelHigh;
    pz_byte_t chSelLow;
    pz_byte_t alternate_function_select;
    pz_byte_t pullDis;
    pz_byte_t dir;
    pz_byte_t analog;
    pz_byte_t digitalIn;
    pz_byte_t next_rdata;

    pz_cfg_if cfg ();

    function automatic logic isMapped(input pz_byte_t a);
        case (a)
            `PZ_ADDR_LATCH, `PZ_ADDR_OD_SEL, `PZ_ADDR_PWM_CTRL,
            `PZ_ADDR_CHSEL_HIGH, `PZ_ADDR_CHSEL_LOW, `PZ_ADDR_ALT_SEL,
            `PZ_ADDR_PULL_DIS, `PZ_ADDR_DIR: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    assign sfrHit = isMapped(sfrAddr);

    // Configuration registers are never touched by the analog override,
    // so leaving analog mode brings back the old digital setup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            latch <= `PZ_LATCH_RST;
            odSel <= `PZ_OD_SEL_RST;
            pwmCtrl <= `PZ_PWM_CTRL_RST;
            chSelHigh <= `PZ_CHSEL_HIGH_RST;
            chSelLow <= `PZ_CHSEL_LOW_RST;
            alternate_function_select <= `PZ_ALT_SEL_RST;
            pullDis <= `PZ_PULL_DIS_RST;
            dir <= `PZ_DIR_RST;
        end else if (ce && sfrWrite) begin
            case (sfrAddr)
                `PZ_ADDR_LATCH: latch <= sfrWdata;
                `PZ_ADDR_OD_SEL: odSel <= sfrWdata;
                `PZ_ADDR_PWM_CTRL: pwmCtrl <= sfrWdata;
                `PZ_ADDR_CHSEL_HIGH: chSelHigh <= sfrWdata;
                `PZ_ADDR_CHSEL_LOW: chSelLow <= sfrWdata;
                `PZ_ADDR_ALT_SEL: alternate_function_select <= sfrWdata & `PZ_ALT_RSVD_MASK;
                `PZ_ADDR_PULL_DIS: pullDis <= sfrWdata;
                `PZ_ADDR_DIR: dir <= sfrWdata;
                default: ;
            endcase
        end
    end

    // Active-low selects; pin zero never carries a channel
    assign analog = {~chSelHigh[`PZ_CHHIGH_MSB:`PZ_CHHIGH_LSB],
        ~chSelLow[`PZ_CHLOW_MSB:`PZ_CHLOW_LSB], 1'b0};

    // Digital input of an analog pin is cut off and reads as one
    assign digitalIn = pinIn | analog;

    assign cfg.dir = dir;
    assign cfg.pullDis = pullDis;
    assign cfg.odSel = odSel;
    assign cfg.latch = latch;
    assign cfg.analog = analog;
    assign cfg.pwmPin6 = pwmCtrl[`PZ_PWM6_BIT];
    assign cfg.txEnable = alternate_function_select[`PZ_ALT_TX_BIT];
    assign cfg.pin0Src = alternate_function_select[`PZ_ALT_PWM0_BIT] ? PZ_SRC_PWM :
        (alternate_function_select[`PZ_ALT_TMR_BIT] ? PZ_SRC_TIMER : PZ_SRC_LATCH);

    always_comb begin
        case (sfrAddr)
            `PZ_ADDR_LATCH: next_rdata = sfrRmw ? latch : digitalIn;
            `PZ_ADDR_OD_SEL: next_rdata = odSel;
            `PZ_ADDR_PWM_CTRL: next_rdata = pwmCtrl;
            `PZ_ADDR_CHSEL_HIGH: next_rdata = chSelHigh;
            `PZ_ADDR_CHSEL_LOW: next_rdata = chSelLow;
            `PZ_ADDR_ALT_SEL: next_rdata = alternate_function_select;
            `PZ_ADDR_PULL_DIS: next_rdata = pullDis;
            `PZ_ADDR_DIR: next_rdata = dir;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sfrRdata <= 8'h00;
        end else if (ce && sfrRead) begin
            sfrRdata <= next_rdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxData <= 1'b1;
        end else if (ce) begin
            rxData <= digitalIn[1];
        end
    end

    pz_pin_drive pinDrive (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .cfg(cfg.pin),
        .timerOverflow(timerOverflow),
        .pwmWave(pwmWave),
        .serialMode0(serialMode0),
        .txData(txData),
        .shiftClk(shiftClk),
        .rxdOut(rxdOut),
        .rxdOe(rxdOe),
        .pinOut(pinOut),
        .pinOe(pinOe),
        .pullupEn(pullupEn),
        .analogEn(analogEn)
    );

    pz_irq_detect irqDetect (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .pinLevel(digitalIn[3:0]),
        .irqEnable(irqEnable),
        .irqLevelMode(irqLevelMode),
        .irqReq(irqReq)
    );

    dir_write_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrWrite && sfrAddr == `PZ_ADDR_DIR |=> dir == $past(sfrWdata))
        else $error("Direction register missed a write");

    rmw_latch_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrRead && sfrRmw && sfrAddr == `PZ_ADDR_LATCH
        |=> sfrRdata == $past(latch))
        else $error("Read-modify-write did not return the latch");

    chan_enable_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrWrite && sfrAddr == `PZ_ADDR_CHSEL_LOW && !sfrWdata[4] ##1 ce
        |=> analogEn[1] && !pinOe[1])
        else $error("Channel zero did not take pin one");

    chan_high_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrWrite && sfrAddr == `PZ_ADDR_CHSEL_HIGH && !sfrWdata[2] ##1 ce
        |=> analogEn[7])
        else $error("Channel six did not take pin seven");

    timer_out_a: assert property (@(posedge mclk) disable iff (rst)
        ce && alternate_function_select[3] && !alternate_function_select[4] && !odSel[0]
        |=> pinOe[0] && pinOut[0] == $past(timerOverflow))
        else $error("Timer overflow not on pin zero");

    tx_route_a: assert property (@(posedge mclk) disable iff (rst)
        ce && alternate_function_select[2] && !serialMode0 && !analog[2] && !odSel[2]
        |=> pinOe[2] && pinOut[2] == $past(txData))
        else $error("Transmit data not on pin two");

    pwm_six_a: assert property (@(posedge mclk) disable iff (rst)
        ce && pwmCtrl[0] && !analog[6] && !odSel[6]
        |=> pinOe[6] && pinOut[6] == $past(pwmWave))
        else $error("Pwm wave not on pin six");

    latch_out_a: assert property (@(posedge mclk) disable iff (rst)
        ce && !dir[5] && !odSel[5] && !analog[5]
        |=> pinOe[5] && pinOut[5] == $past(latch[5]))
        else $error("Latch value not driven on pin five");

    freeze_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !ce |=> $stable(latch) && $stable(dir) && $stable(pinOut) && $stable(pinOe))
        else $error("State changed while the clock enable was low");

    latch_write_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrWrite && sfrAddr == `PZ_ADDR_LATCH |=> latch == $past(sfrWdata))
        else $error("Data latch missed a write");

    od_write_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrWrite && sfrAddr == `PZ_ADDR_OD_SEL |=> odSel == $past(sfrWdata))
        else $error("Output-type register missed a write");

    pull_write_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrWrite && sfrAddr == `PZ_ADDR_PULL_DIS |=> pullDis == $past(sfrWdata))
        else $error("Pull-up register missed a write");

    analog_read_a: assert property (@(posedge mclk) disable iff (rst)
        ce && sfrRead && !sfrRmw && sfrAddr == `PZ_ADDR_LATCH
        |=> (sfrRdata & $past(analog)) == $past(analog))
        else $error("Analog pin did not read as one");

    read_hold_a: assert property (@(posedge mclk) disable iff (rst)
        ce && !sfrRead |=> $stable(sfrRdata))
        else $error("Read data changed without a read");

    analog_pull_a: assert property (@(posedge mclk) disable iff (rst)
        (pullupEn & analogEn) == 8'h00)
        else $error("Pull-up left on at an analog pin");

    restore_drive_a: assert property (@(posedge mclk) disable iff (rst)
        ce && $fell(analog[1]) && !dir[1] && !odSel[1] && !alternate_function_select[`PZ_ALT_TX_BIT]
        |=> pinOe[1])
        else $error("Pin one did not return to output");

    restore_pull_a: assert property (@(posedge mclk) disable iff (rst)
        ce && $fell(analog[3]) && !pullDis[3] |=> pullupEn[3])
        else $error("Pull-up on pin three did not come back");

    chan_off_a: assert property (@(posedge mclk) disable iff (rst)
        ce && (&chSelLow[`PZ_CHLOW_MSB:`PZ_CHLOW_LSB])
        && (&chSelHigh[`PZ_CHHIGH_MSB:`PZ_CHHIGH_LSB]) |=> analogEn == 8'h00)
        else $error("Analog channel on with its select bit high");

    digital_zero_a: assert property (@(posedge mclk) disable iff (rst)
        analogEn[0] == 1'b0)
        else $error("Pin zero was handed to the converter");

    off_three_a: assert property (@(posedge mclk) disable iff (rst)
        ce && !irqEnable[3] |=> !irqReq[3])
        else $error("Disabled interrupt three requested");

    off_two_a: assert property (@(posedge mclk) disable iff (rst)
        ce && !irqEnable[2] |=> !irqReq[2])
        else $error("Disabled interrupt two requested");

    edge_zero_a: assert property (@(posedge mclk) disable iff (rst)
        ce && digitalIn[0] ##1 ce && irqEnable[0] && !digitalIn[0] |=> irqReq[0])
        else $error("Falling edge on interrupt zero missed");

    level_one_a: assert property (@(posedge mclk) disable iff (rst)
        ce && irqEnable[1] && irqLevelMode[1] && !digitalIn[1] |=> irqReq[1])
        else $error("Low level on interrupt one missed");

    shift_clock_a: assert property (@(posedge mclk) disable iff (rst)
        ce && alternate_function_select[`PZ_ALT_TX_BIT] && serialMode0 && !analog[2] && !odSel[2]
        |=> pinOe[2] && pinOut[2] == $past(shiftClk))
        else $error("Shift clock not on pin two");

    rxd_drive_a: assert property (@(posedge mclk) disable iff (rst)
        ce && alternate_function_select[`PZ_ALT_TX_BIT] && serialMode0 && rxdOe && !analog[1] && !odSel[1]
        |=> pinOe[1] && pinOut[1] == $past(rxdOut))
        else $error("Mode zero data not driven on pin one");

    rx_data_a: assert property (@(posedge mclk) disable iff (rst)
        ce && !analog[1] |=> rxData == $past(pinIn[1]))
        else $error("Received data does not follow pin one");

    od_sink_a: assert property (@(posedge mclk) disable iff (rst)
        ce && odSel[4] && !dir[4] && !latch[4] && !analog[4]
        |=> pinOe[4] && !pinOut[4])
        else $error("Open-drain pin does not sink low");

    pwm_zero_a: assert property (@(posedge mclk) disable iff (rst)
        ce && alternate_function_select[`PZ_ALT_PWM0_BIT] && !odSel[0]
        |=> pinOe[0] && pinOut[0] == $past(pwmWave))
        else $error("Pwm wave not on pin zero");
endmodule // pz_port0

// >>> dv/pz_pin_model.sv
module pz_pin_model (
    input wire logic mclk,
    input pz_pkg::pz_byte_t pinOut,
    input pz_pkg::pz_byte_t pinOe,
    input pz_pkg::pz_byte_t pullupEn,
    input pz_pkg::pz_byte_t extDrv,
    input pz_pkg::pz_byte_t extOe,
    output pz_pkg::pz_byte_t pinLevel
);
    timeunit 1ns;
    timeprecision 100ps;
    import pz_pkg::*;
    // Undriven pins without pull-up wander, so a stale value never passes
    pz_byte_t floatVal = 8'h55;
    always @(posedge mclk) begin
        floatVal <= ~floatVal;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinOe[i]) begin
                pinLevel[i] = pinOut[i];
            end else if (extOe[i]) begin
                pinLevel[i] = extDrv[i];
            end else if (pullupEn[i]) begin
                pinLevel[i] = 1'b1;
            end else begin
                pinLevel[i] = floatVal[i];
            end
        end
    end
endmodule // pz_pin_model

// >>> dv/testbench.sv
`include "pz_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pz_pkg::*;
    logic mclk, rst, ce, sfrWrite, sfrRead, sfrRmw, sfrHit, rxData;
    logic timerOverflow, pwmWave, serialMode0, txData, shiftClk, rxdOut, rxdOe;
    pz_byte_t sfrAddr, sfrWdata, sfrRdata, pinIn, pinOut, pinOe, pullupEn, analogEn;
    pz_byte_t extDrv, extOe, d;
    pz_irq_t irqEnable, irqReq;
    logic [1:0] irqLevelMode;
    int error_cnt = 0;
    int n_tests = 0;

    pz_port0 i_pz_port0 (.mclk(mclk), .rst(rst), .ce(ce), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRmw(sfrRmw),
        .sfrRdata(sfrRdata), .sfrHit(sfrHit), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pullupEn(pullupEn), .analogEn(analogEn),
        .timerOverflow(timerOverflow), .pwmWave(pwmWave), .serialMode0(serialMode0),
        .txData(txData), .shiftClk(shiftClk), .rxdOut(rxdOut), .rxdOe(rxdOe),
        .rxData(rxData), .irqEnable(irqEnable), .irqLevelMode(irqLevelMode),
        .irqReq(irqReq));
    pz_pin_model i_pz_pin_model (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe),
        .pullupEn(pullupEn), .extDrv(extDrv), .extOe(extOe), .pinLevel(pinIn));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input pz_byte_t got, input pz_byte_t exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe for one edge, then one more edge so the pins have followed
    task automatic wr(input pz_byte_t a, input pz_byte_t v);
        sfrAddr = a;
        sfrWdata = v;
        sfrWrite = 1'b1;
        @(negedge mclk);
        sfrWrite = 1'b0;
        @(negedge mclk);
    endtask

    task automatic rd(input pz_byte_t a, input logic rmw, output pz_byte_t v);
        sfrAddr = a;
        sfrRmw = rmw;
        sfrRead = 1'b1;
        @(negedge mclk);
        v = sfrRdata;
        sfrRead = 1'b0;
        sfrRmw = 1'b0;
        // A spare edge keeps back-to-back reads from retoggling the strobe
        @(negedge mclk);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic t_reset;
        pz_byte_t adr[8] = '{`PZ_ADDR_LATCH, `PZ_ADDR_OD_SEL, `PZ_ADDR_PWM_CTRL,
            `PZ_ADDR_CHSEL_HIGH, `PZ_ADDR_CHSEL_LOW, `PZ_ADDR_ALT_SEL,
            `PZ_ADDR_PULL_DIS, `PZ_ADDR_DIR};
        pz_byte_t exp[8] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff};
        for (int i = 0; i < 8; i++) begin
            rd(adr[i], 1'b1, d);
            chk(d, exp[i]);
        end
        chk(pinOe, 8'h00);
        chk(pullupEn, 8'hff);
        chk(analogEn, 8'h00);
        rd(8'h81, 1'b0, d);
        chk({7'h00, sfrHit}, 8'h00);
        chk(d, 8'h00);
        $display("t_reset done");
    endtask

    task automatic t_output;
        wr(`PZ_ADDR_DIR, 8'h00);
        wr(`PZ_ADDR_LATCH, 8'ha5);
        chk(pinOe, 8'hff);
        chk(pinOut, 8'ha5);
        wr(`PZ_ADDR_OD_SEL, 8'hf0);
        chk(pinOe, 8'h5f);
        chk(pinOut & pinOe, 8'h05);
        wr(`PZ_ADDR_OD_SEL, 8'h00);
        wr(`PZ_ADDR_DIR, 8'hff);
        chk(pinOe, 8'h00);
        $display("t_output done");
    endtask

    task automatic t_pull_rmw;
        wr(`PZ_ADDR_PULL_DIS, 8'h0f);
        chk(pullupEn, 8'hf0);
        extDrv = 8'h3c;
        extOe = 8'hff;
        wait_n(2);
        rd(`PZ_ADDR_LATCH, 1'b1, d);
        chk(d, 8'ha5);
        rd(`PZ_ADDR_LATCH, 1'b0, d);
        chk(d, 8'h3c);
        extOe = 8'h00;
        wr(`PZ_ADDR_PULL_DIS, 8'h00);
        $display("t_pull_rmw done");
    endtask

    task automatic t_analog;
        wr(`PZ_ADDR_DIR, 8'h00);
        wr(`PZ_ADDR_CHSEL_LOW, 8'h0f);
        chk(analogEn, 8'h1e);
        chk(pinOe, 8'he1);
        wr(`PZ_ADDR_CHSEL_HIGH, 8'hf8);
        chk(analogEn, 8'hfe);
        chk(pinOe, 8'h01);
        wait_n(2);
        rd(`PZ_ADDR_LATCH, 1'b0, d);
        chk(d, 8'hff);
        wr(`PZ_ADDR_CHSEL_LOW, 8'hff);
        wr(`PZ_ADDR_CHSEL_HIGH, 8'hff);
        chk(analogEn, 8'h00);
        chk(pinOe, 8'hff);
        wr(`PZ_ADDR_DIR, 8'hff);
        $display("t_analog done");
    endtask

    task automatic t_alt;
        timerOverflow = 1'b1;
        wr(`PZ_ADDR_ALT_SEL, 8'h08);
        chk(pinOe & 8'h01, 8'h01);
        chk(pinOut & 8'h01, 8'h01);
        timerOverflow = 1'b0;
        wait_n(1);
        chk(pinOut & 8'h01, 8'h00);
        timerOverflow = 1'b1;
        wr(`PZ_ADDR_ALT_SEL, 8'h18);
        chk(pinOut & 8'h01, 8'h00);
        pwmWave = 1'b1;
        wait_n(1);
        chk(pinOut & 8'h01, 8'h01);
        wr(`PZ_ADDR_PWM_CTRL, 8'h01);
        chk(pinOe & 8'h41, 8'h41);
        pwmWave = 1'b0;
        wait_n(1);
        chk(pinOut & 8'h41, 8'h00);
        wr(`PZ_ADDR_PWM_CTRL, 8'h00);
        wr(`PZ_ADDR_ALT_SEL, 8'h00);
        chk(pinOe, 8'h00);
        $display("t_alt done");
    endtask

    task automatic t_serial;
        txData = 1'b0;
        shiftClk = 1'b1;
        wr(`PZ_ADDR_ALT_SEL, 8'h04);
        chk(pinOe & 8'h04, 8'h04);
        chk(pinOut & 8'h04, 8'h00);
        txData = 1'b1;
        wait_n(1);
        chk(pinOut & 8'h04, 8'h04);
        serialMode0 = 1'b1;
        shiftClk = 1'b0;
        rxdOe = 1'b1;
        rxdOut = 1'b1;
        wait_n(1);
        chk(pinOut & 8'h04, 8'h00);
        chk(pinOe & pinOut & 8'h02, 8'h02);
        serialMode0 = 1'b0;
        rxdOe = 1'b0;
        extDrv = 8'h00;
        extOe = 8'h02;
        wait_n(3);
        chk({7'h00, rxData}, 8'h00);
        extDrv = 8'h02;
        wait_n(3);
        chk({7'h00, rxData}, 8'h01);
        extOe = 8'h00;
        wr(`PZ_ADDR_ALT_SEL, 8'h00);
        $display("t_serial done");
    endtask

    // Counts request cycles over five edges after the pins change
    task automatic step(input pz_byte_t drv, input int idx, input pz_byte_t exp);
        pz_byte_t n;
        n = 8'h00;
        extDrv = drv;
        repeat (5) begin
            @(negedge mclk);
            if (irqReq[idx] === 1'b1) n++;
        end
        chk(n, exp);
    endtask

    task automatic t_irq;
        irqEnable = 4'hf;
        extDrv = 8'h0f;
        extOe = 8'h0f;
        wait_n(3);
        step(8'h07, 3, 8'h01);
        step(8'h0f, 3, 8'h00);
        step(8'h0b, 2, 8'h00);
        step(8'h0f, 2, 8'h01);
        step(8'h0d, 1, 8'h01);
        step(8'h0f, 1, 8'h00);
        step(8'h0e, 0, 8'h01);
        irqLevelMode = 2'h3;
        wait_n(2);
        step(8'h0e, 0, 8'h05);
        step(8'h0c, 2, 8'h00);
        step(8'h0c, 1, 8'h05);
        irqEnable = 4'h0;
        wait_n(2);
        step(8'h0c, 0, 8'h00);
        extOe = 8'h00;
        $display("t_irq done");
    endtask

    // Frozen clock enable blocks a write; a mid-run reset restores the latch
    task automatic t_freeze;
        ce = 1'b0;
        wr(`PZ_ADDR_DIR, 8'h00);
        chk(pinOe, 8'h00);
        ce = 1'b1;
        rd(`PZ_ADDR_DIR, 1'b0, d);
        chk(d, 8'hff);
        chk({7'h00, sfrHit}, 8'h01);
        wr(`PZ_ADDR_LATCH, 8'h00);
        rst = 1'b1;
        wait_n(2);
        rst = 1'b0;
        rd(`PZ_ADDR_LATCH, 1'b1, d);
        chk(d, 8'hff);
        $display("t_freeze done");
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {rst, ce, sfrWrite, sfrRead, sfrRmw} = 5'h18;
        {timerOverflow, pwmWave, serialMode0, shiftClk, rxdOut, rxdOe} = 6'h00;
        txData = 1'b1;
        sfrAddr = 8'h00;
        sfrWdata = 8'h00;
        irqEnable = 4'h0;
        irqLevelMode = 2'h0;
        extDrv = 8'h00;
        extOe = 8'h00;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        wait_n(2);
        t_reset();
        t_output();
        t_pull_rmw();
        t_analog();
        t_alt();
        t_serial();
        t_irq();
        t_freeze();
        end_of_test();
    end

    // The whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule // testbench
